// >>> dv/deser_model.sv
// Far-side deserializer model that forwards its general pin levels over the link.
`timescale 1ns/1ps
`default_nettype none
module deser_model (
    input  wire logic       clk,
    input  wire logic [3:0] gpio_level,
    output logic      [3:0] remote_pin
);
    // Values land on the falling edge, so the block sees them unaligned to its sampling edge.
    always @(negedge clk)
    begin
        remote_pin <= gpio_level;
    end
endmodule
`default_nettype wire

// >>> dv/gpo_strap_chk.sv
// Checker for the general output routing and strap control block.
`timescale 1ns/1ps
`default_nettype none
module gpo_strap_chk (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       power_down_n,
    input wire logic [3:0] remote_pin,
    input wire logic [3:0] local_bit,
    input wire logic [3:0] source_select,
    input wire logic       clock_out_enable,
    input wire logic       ref_clock_src,
    input wire logic       strobe_edge_select,
    input wire logic       pixel_rise_sample,
    input wire logic [3:0] general_output,
    input wire logic [3:0] general_output_oe,
    input wire logic       ext_osc_mode,
    input wire logic       pll_enable,
    input wire logic       device_enabled,
    input wire logic [2:0] target_address,
    input wire logic       pixel_sample,
    input wire logic       reserved_fault
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Power-down must outlast the pin synchroniser before the outputs are judged.
    sequence off_s;
        !power_down_n [*8];
    endsequence
    sequence rem_hi_s;
        (device_enabled && !source_select[1] && remote_pin[1]) [*6];
    endsequence
    a_off_quiet: assert property (off_s |-> !device_enabled && !pll_enable && general_output_oe == 4'h0)
        else $error("device live in power down");
    a_local_route: assert property ((device_enabled && source_select[0] && local_bit[0]) [*3] |=> general_output[0])
        else $error("local bit not routed");
    a_remote_route: assert property (rem_hi_s |=> general_output[1])
        else $error("remote pin not routed");
    a_strap_hold: assert property (device_enabled && $past(device_enabled) |-> $stable(target_address) && $stable(ext_osc_mode))
        else $error("strap capture moved");
    a_ref_clock_in_oe: assert property (ext_osc_mode |-> !general_output_oe[3])
        else $error("clock input pin driven");
    a_clk_out: assert property ((device_enabled && ext_osc_mode && clock_out_enable && ref_clock_src) [*3] |=> general_output[2])
        else $error("clock not on output two");
    a_edge_pick: assert property ((device_enabled && strobe_edge_select && pixel_rise_sample) [*2] |=> pixel_sample)
        else $error("wrong strobe edge");
    a_fault_sticky: assert property (reserved_fault && power_down_n && device_enabled |=> reserved_fault)
        else $error("reserved fault dropped");
    a_fault_quiet: assert property (!reserved_fault)
        else $error("reserved fault without cause");
endmodule
bind gpo_strap_ctrl gpo_strap_chk i_gpo_strap_chk (.clk, .resetn, .power_down_n, .remote_pin,
    .local_bit, .source_select, .clock_out_enable, .ref_clock_src, .strobe_edge_select,
    .pixel_rise_sample, .general_output, .general_output_oe, .ext_osc_mode, .pll_enable,
    .device_enabled, .target_address, .pixel_sample, .reserved_fault);
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the general output routing and strap control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, power_down_n = 1'b0, mode_strap = 1'b0;
    logic reserved_strap = 1'b0, clock_out_enable = 1'b0, ref_clock_src = 1'b0;
    logic strobe_edge_select = 1'b0, pixel_rise_sample = 1'b0, pixel_fall_sample = 1'b0;
    logic [2:0] address_strap = 3'h0;
    logic [3:0] local_bit = 4'h0, source_select = 4'h0, general_output_in = 4'h0, gpio = 4'h0;
    wire logic [3:0] remote_pin, general_output, general_output_oe;
    wire logic [2:0] target_address;
    wire logic ref_clock_in, ext_osc_mode, pll_enable, device_enabled, pixel_sample;
    wire logic reserved_fault;
    int err_count = 0, compares = 0, cyc = 0;
    logic [7:0] rnd = 8'h2D;
    gpo_strap_ctrl i_gpo_strap_ctrl (.clk, .resetn, .power_down_n, .mode_strap, .address_strap,
        .reserved_strap, .remote_pin, .local_bit, .source_select, .clock_out_enable,
        .ref_clock_src, .strobe_edge_select, .pixel_rise_sample, .pixel_fall_sample,
        .general_output_in, .general_output, .general_output_oe, .ref_clock_in, .ext_osc_mode,
        .pll_enable, .device_enabled, .target_address, .pixel_sample, .reserved_fault);
    deser_model i_deser_model (.clk, .gpio_level(gpio), .remote_pin);
    initial
    begin
        forever #5 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    task automatic conclude();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Straps are moved after capture; the block must keep the captured values.
    task automatic power_up(input logic m, input logic [2:0] a);
        mode_strap = m;
        address_strap = a;
        reserved_strap = 1'b0;
        power_down_n = 1'b1;
        repeat (12) @(negedge clk);
        chk("enables", 8'h03, {pll_enable, device_enabled});
        chk("ext_osc_mode", m, ext_osc_mode);
        chk("target_address", a, target_address);
        chk("reserved_fault", 8'h00, reserved_fault);
        address_strap = ~a;
        mode_strap = ~m;
    endtask
    // One random pattern, then the reference model's outputs after the synchroniser settles.
    task automatic step(input logic m);
        logic [3:0] e, oe;
        rnd = lfsr(rnd);
        {source_select, local_bit} = rnd;
        rnd = lfsr(rnd);
        {ref_clock_src, clock_out_enable, strobe_edge_select, pixel_rise_sample, gpio} = rnd;
        rnd = lfsr(rnd);
        {general_output_in, pixel_fall_sample} = rnd[4:0];
        repeat (10) @(negedge clk);
        for (int i = 0; i < 4; i++) e[i] = source_select[i] ? local_bit[i] : gpio[i];
        if (m && clock_out_enable) e[2] = ref_clock_src;
        oe = m ? 4'h7 : 4'hF;
        chk("general_output", e & oe, general_output & oe);
        chk("output_enable", oe, general_output_oe);
        chk("ref_clock_in", m & general_output_in[3], ref_clock_in);
        e[0] = strobe_edge_select ? pixel_rise_sample : pixel_fall_sample;
        chk("pixel_sample", e[0], pixel_sample);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            conclude();
        end
    end
    initial
    begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            rnd = lfsr(rnd);
            power_up(m[0], rnd[2:0]);
            repeat (8) step(m[0]);
            chk("held_address", {5'h00, ~address_strap}, target_address);
            power_down_n = 1'b0;
            repeat (10) @(negedge clk);
            chk("off_state", 8'h00, {general_output_oe, pll_enable, device_enabled});
            chk("off_fault", 8'h00, reserved_fault);
            chk("off_output", gpo_strap_pkg::RESET_OUT, general_output);
            chk("off_address", gpo_strap_pkg::RESET_ADDR, target_address);
        end
        conclude();
    end
endmodule
`default_nettype wire

// >>> src/gpo_strap_ctrl.sv
// General output routing, clock mode strap and address strap control.
//
// Function
// R1: Outputs 0,1 from remote pin or local bit.
// R2: Output 2 remote/local, or reference clock out.
// R3: Output 3 remote/local, or clock input.
// R4: Mode strap picks pixel clock or oscillator.
// R5: Address strap sets control bus address.
// R6: Power-down input high means fully operating.
// R7: Power-down low stops PLL, resets configuration.
// R8: Reserved strap held low by system.
// R9: Pixel inputs sampled on selected edge.
// R10: Remote pin values synchronised before outputs.
`timescale 1ns/1ps
`default_nettype none
module gpo_strap_ctrl #(
    parameter int unsigned NUM_OUT = gpo_strap_pkg::NUM_OUTPUTS,
    parameter int unsigned ADDR_W  = gpo_strap_pkg::ADDR_W
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               power_down_n,
    input  wire logic               mode_strap,
    input  wire logic [ADDR_W-1:0]  address_strap,
    input  wire logic               reserved_strap,
    input  wire logic [NUM_OUT-1:0] remote_pin,
    input  wire logic [NUM_OUT-1:0] local_bit,
    input  wire logic [NUM_OUT-1:0] source_select,
    input  wire logic               clock_out_enable,
    input  wire logic               ref_clock_src,
    input  wire logic               strobe_edge_select,
    input  wire logic               pixel_rise_sample,
    input  wire logic               pixel_fall_sample,
    input  wire logic [NUM_OUT-1:0] general_output_in,
    output logic      [NUM_OUT-1:0] general_output,
    output logic      [NUM_OUT-1:0] general_output_oe,
    output logic                    ref_clock_in,
    output logic                    ext_osc_mode,
    output logic                    pll_enable,
    output logic                    device_enabled,
    output logic [ADDR_W-1:0]       target_address,
    output logic                    pixel_sample,
    output logic                    reserved_fault
);
    // Operating state of the device.
    // The device is either off, capturing its straps, or running. The separate
    // capture state gives the strap synchronisers one settled cycle first.
    typedef enum logic [1:0] {
        ST_OFF     = 2'b00,  // Powered down, configuration at defaults.
        ST_LATCH   = 2'b01,  // Capturing straps after power-up.
        ST_RUN     = 2'b10   // Enabled and fully operating.
    } op_state_t;

    // All state lives in one packed word, so reset clears it in one place.
    typedef struct packed {
        op_state_t          state;
        logic               ext_mode;   // Captured clock mode strap.
        logic [ADDR_W-1:0]  addr;       // Captured address strap.
        logic [NUM_OUT-1:0] out;        // Registered general output values.
        logic [NUM_OUT-1:0] oe;         // Output enables.
        logic               sample;     // Selected pixel edge sample.
        logic               res_fault;  // Reserved strap seen high.
        logic               clk_in;     // Registered clock input level.
    } ctrl_state_t;

    ctrl_state_t st_q;  // Registered state.
    ctrl_state_t st_d;  // Next state.

    // Synchronised versions of every input that comes from a pin or the link.
    // Each passes three stages and an output register and counts once stages two and three agree,
    // which costs about four cycles of latency on every strap and remote value.
    logic [NUM_OUT-1:0] remote_s;  // Remote pin values in local domain.
    logic               pdn_s;     // Power-down level.
    logic               mode_s;    // Clock mode strap level.
    logic [ADDR_W-1:0]  addr_s;    // Address strap level.
    logic               res_s;     // Reserved strap level.
    logic               ref_clock_in_s;   // Clock input arriving on output 3.

    // Elaboration checks: the routing is written for exactly four outputs.
    if (NUM_OUT != gpo_strap_pkg::NUM_OUTPUTS)
    begin
        $error("gpo_strap_ctrl serves exactly four general outputs.");
    end
    // An address strap needs at least one bit to hold a level.
    if (ADDR_W < 1)
    begin
        $error("gpo_strap_ctrl needs ADDR_W of at least one.");
    end

    // Remote values cross into the local clock before reaching the pins. [R10]
    // Reset clears the stages, so remote values read low until the link settles.
    pin_sync #(.WIDTH(NUM_OUT)) u_remote_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (remote_pin),
        .sync_out (remote_s)
    );

    // Straps, power-down and the clock input are also pins, so they are filtered too.
    // The clock input shares this filter, which limits the usable oscillator rate.
    pin_sync #(.WIDTH(ADDR_W + 4)) u_strap_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in ({power_down_n, mode_strap, address_strap, reserved_strap,
                    general_output_in[gpo_strap_pkg::CLK_IN_INDEX]}),
        .sync_out ({pdn_s, mode_s, addr_s, res_s, ref_clock_in_s})
    );

    // Pick the source of one output: remote pin value or local bit.
    // Kept as a function so the same decode serves every output in the loop.
    function automatic logic route_bit(input logic sel, input logic rem, input logic loc);
        begin
            route_bit = (sel == gpo_strap_pkg::SRC_LOCAL) ? loc : rem;
        end
    endfunction

    // Next-state logic: power sequencing, strap capture and output routing.
    always_comb
    begin
        // Every field holds unless a branch below says otherwise.
        st_d = st_q;
        // The clock input is registered in every state and masked by the mode bit,
        // so it can never show while the pin is still an ordinary output.
        st_d.clk_in = st_q.ext_mode & ref_clock_in_s;  // [R3]
        case (st_q.state)
            ST_OFF:
            begin
                // Configuration returns to defaults while powered down. [R7]
                st_d.ext_mode  = gpo_strap_pkg::MODE_PIXEL;
                st_d.addr      = ADDR_W'(gpo_strap_pkg::RESET_ADDR);
                st_d.out       = NUM_OUT'(gpo_strap_pkg::RESET_OUT);
                // With the enables low the pins fall to whatever the board pulls them to.
                st_d.oe        = '0;
                st_d.sample    = 1'b0;
                st_d.res_fault = 1'b0;
                // Leave off only once the filtered power-down input reads high. [R6]
                if (pdn_s)
                begin
                    st_d.state = ST_LATCH;
                end
            end
            ST_LATCH:
            begin
                // Straps are captured once, so later pin noise cannot move them. [R4] [R5]
                st_d.ext_mode = mode_s;
                st_d.addr     = addr_s;
                // Power-down passed the same filter, so the straps have settled by now.
                // A power-down that arrives during capture drops straight back to off.
                st_d.state    = pdn_s ? ST_RUN : ST_OFF;
            end
            ST_RUN:
            begin
                if (!pdn_s)
                begin
                    // The outputs stand one cycle more; the off state then clears them.
                    st_d.state = ST_OFF;  // [R7]
                end
                else
                begin
                    // Fully operating while power-down input stays high. [R6]
                    for (int i = 0; i < NUM_OUT; i++)
                    begin
                        // Route each output from its chosen source. [R1]
                        st_d.out[i] = route_bit(source_select[i], remote_s[i], local_bit[i]);
                        // Every output drives its pin while the device runs, except output 3 in oscillator mode.
                        st_d.oe[i]  = 1'b1;
                    end
                    // Output 2 carries the reference clock in oscillator mode. [R2]
                    // Without the enable the pin stays an ordinary output in either mode.
                    if (st_q.ext_mode == gpo_strap_pkg::MODE_EXT_OSC && clock_out_enable)
                    begin
                        st_d.out[gpo_strap_pkg::CLK_OUT_INDEX] = ref_clock_src;
                    end
                    // Output 3 turns into the clock input in oscillator mode. [R3]
                    // Its output bit is parked low so nothing stale shows if the mode changes.
                    if (st_q.ext_mode == gpo_strap_pkg::MODE_EXT_OSC)
                    begin
                        st_d.out[gpo_strap_pkg::CLK_IN_INDEX] = 1'b0;
                        st_d.oe[gpo_strap_pkg::CLK_IN_INDEX]  = 1'b0;
                    end
                    // Pixel inputs take the sample of the selected edge. [R9]
                    // The edge choice is a live input, so a change acts on the next cycle.
                    st_d.sample = strobe_edge_select ? pixel_rise_sample : pixel_fall_sample;
                    // The system must hold the reserved strap low; flag it sticky if not. [R8]
                    // Only the off state clears it, so a violation held long enough to pass the strap filter is never lost.
                    st_d.res_fault = st_q.res_fault | res_s;
                end
            end
            default:
            begin
                // An unused state code recovers to off.
                st_d.state = ST_OFF;
            end
        endcase
    end

    // All state clears on reset, which is the off state with defaults.
    // The reset branch loads constants only.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Data outputs come straight from registers, so the pins never glitch.
    // Enable and PLL status are decoded from the state register and change together.
    assign general_output    = st_q.out;
    assign general_output_oe = st_q.oe;
    assign ref_clock_in      = st_q.clk_in;  // [R3]
    assign ext_osc_mode      = st_q.ext_mode;
    assign pll_enable        = (st_q.state == ST_RUN);  // [R7]
    assign device_enabled    = (st_q.state == ST_RUN);  // [R6]
    assign target_address    = st_q.addr;
    assign pixel_sample      = st_q.sample;
    assign reserved_fault    = st_q.res_fault;
endmodule
`default_nettype wire

// >>> src/gpo_strap_pkg.sv
// Shared constants for the general output routing and strap control block.
`default_nettype none
package gpo_strap_pkg;
    localparam int unsigned NUM_OUTPUTS   = 4;
    localparam int unsigned ADDR_W        = 3;
    localparam int unsigned SYNC_STAGES   = 3;
    // General output whose pin may carry the reference clock out.
    localparam int unsigned CLK_OUT_INDEX = 2;
    // General output whose pin may accept the reference clock in.
    localparam int unsigned CLK_IN_INDEX  = 3;
    // Source select encoding per output: 0 = remote pin, 1 = local bit.
    localparam logic        SRC_REMOTE    = 1'b0;
    localparam logic        SRC_LOCAL     = 1'b1;
    // Clock mode strap encoding: 0 = pixel clock, 1 = external oscillator.
    localparam logic        MODE_PIXEL    = 1'b0;
    localparam logic        MODE_EXT_OSC  = 1'b1;
    // Reset values of the configuration state.
    localparam logic [3:0]  RESET_OUT     = 4'h0;
    localparam logic [2:0]  RESET_ADDR    = 3'h0;
endpackage
`default_nettype wire

// >>> src/pin_sync.sv
// Three-stage input synchroniser with a second and third stage agreement filter.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // The first stage only feeds the second, so metastability stays contained.
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_state_t;

    sync_state_t st_q;  // Registered state.
    sync_state_t st_d;  // Next state.

    // Elaboration check: a zero-width synchroniser has nothing to carry.
    if (WIDTH < 1)
    begin
        $error("pin_sync needs WIDTH of at least one.");
    end

    // A change is accepted only once the second and third stages agree.
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end

    // Stages clear to zero under reset.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.out;
endmodule
`default_nettype wire
